// ==== asi_bank_defs.svh ====
// constants for the bank and safety data path
`ifndef ASI_BANK_DEFS_SVH
`define ASI_BANK_DEFS_SVH
`define ADDR_CTRL 12'h000
`define ADDR_INVERT 12'h004
`define ADDR_STATUS 12'h008
`define CTRL_EXT_ADDR 0
`define CTRL_SPLIT_BANK 1
`define CTRL_SAFETY 2
`define CTRL_SYNC_IO 3
`define CTRL_SLAVE_B 4
`define CTRL_JOINT_INV 5
`define CTRL_RESET 6'h00
`define INV_BIT_LO 0
`define INV_BIT_HI 3
`define FILT_LO 4
`define FILT_HI 7
`define INFO_I0 0
`define INFO_I1 1
`define INFO_I2 2
`define INFO_I3 3
`define NIBBLE_ZERO 4'h0
`define NIBBLE_ONES 4'hF
`define WORD_ZERO 32'h0000_0000
`endif

// ==== asi_bank_pkg.sv ====
// types for the bank and safety data path
package asi_bank_pkg;
    typedef struct packed {
        logic ext_addr;
        logic split_bank_output_enable;
        logic safety;
        logic sync_io;
        logic slave_b;
        logic joint_inv;
        logic [3:0] per_bit_input_invert_ctrl;
        logic [3:0] input_filter_ctrl;
        logic [3:0] output_pin;
        logic low_bank_hold_bit0;
        logic low_bank_hold_bit1;
        logic prev_i2;
        logic dx_disable;
        logic [3:0] resp_data;
        logic resp_valid;
        logic data_strobe;
        logic [31:0] prdata;
    } state_t;
endpackage : asi_bank_pkg

// ==== safety_recoder.sv ====
// input inversion, standard path and safety recoding
`timescale 1ns/1ps
`include "asi_bank_defs.svh"
module safety_recoder import asi_bank_pkg::*; (
    input wire logic [3:0] input_pin,
    input wire logic joint_inv,
    input wire logic [3:0] per_bit_input_invert_ctrl,
    input wire logic safety,
    output logic [3:0] std_path,
    output logic [3:0] safe_path,
    output logic [3:0] tx_data
);
    logic [3:0] inv;
    logic [3:0] sw;
    // inversion ahead of recoding; per-bit control stays on physical pins
    assign inv = input_pin ^ (joint_inv ? `NIBBLE_ONES : `NIBBLE_ZERO) ^ per_bit_input_invert_ctrl;
    // logical inputs two and three swapped
    assign sw = {inv[2], inv[3], inv[1], inv[0]};
    assign safe_path = {sw[3:1], sw[0] ^ (sw[1] & sw[2] & sw[3])};
    // standard path tied high in safety mode
    assign std_path = inv | {4{safety}};
    assign tx_data = safety ? safe_path : std_path;
endmodule : safety_recoder

// ==== asi_bank_datapath.sv ====
// slave data port path: split output banks and safety input recoding
// Contract
// - in extended address mode I3 picks the A-slave or the B-slave.
// - extended mode plus four-output flag makes I2 the bank selector.
// - in four-output mode, outputs and strobe only on I2 low following a call with I2 high.
// - the I2 edge detector starts with previous I2 taken as low.
// - inputs are sampled and returned on every call, whatever I2.
// - I2 high stores I0 and I1 into hold bits, pins unchanged.
// - qualifying I2 low drives I0,I1 to pins 2,3 and hold bits to 0,1.
// - the safety flag turns safety mode on.
// - a safety-controlled selector picks the path; off means regular path.
// - safety mode swaps logical inputs two and three.
// - joint and per-bit inversion stay available, applied before recoding.
// - per-bit invert bit 3 inverts logical two, bit 2 logical three.
// - in safety mode D0 is sent as D0 xor (D1 and D2 and D3).
// - safety mode forces every standard path bit to one.
// - safety with sync I/O or any filter never clears exchange disable.
`timescale 1ns/1ps
`include "asi_bank_defs.svh"
module asi_bank_datapath import asi_bank_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dexg_valid,
    input wire logic [3:0] dexg_info,
    input wire logic param_call,
    input wire logic [3:0] input_pin,
    output logic [3:0] output_pin,
    output logic data_strobe,
    output logic [3:0] resp_data,
    output logic resp_valid,
    output logic dx_disable
);
    state_t state_q;
    state_t state_d;
    logic [3:0] std_path;
    logic [3:0] safe_path;
    logic [3:0] tx_data;
    logic accept;
    logic four_mode;
    logic lock;
    logic mapped;

    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `ADDR_CTRL) || (a == `ADDR_INVERT) || (a == `ADDR_STATUS);
    endfunction : addr_hit

    safety_recoder u_recoder (
        .input_pin(input_pin),
        .joint_inv(state_q.joint_inv),
        .per_bit_input_invert_ctrl(state_q.per_bit_input_invert_ctrl),
        .safety(state_q.safety),
        .std_path(std_path),
        .safe_path(safe_path),
        .tx_data(tx_data)
    );

    assign four_mode = state_q.ext_addr && state_q.split_bank_output_enable;
    // call addressed to this half of the shared address
    assign accept = dexg_valid && !state_q.dx_disable &&
        (!state_q.ext_addr || (dexg_info[`INFO_I3] == state_q.slave_b));
    assign lock = state_q.safety && (state_q.sync_io || (state_q.input_filter_ctrl != `NIBBLE_ZERO));
    assign mapped = addr_hit(paddr);

    always_comb begin
        state_d = state_q;
        state_d.data_strobe = 1'b0;
        state_d.resp_valid = 1'b0;
        // register writes at the access edge
        if (psel && penable && pwrite && paddr == `ADDR_CTRL) begin
            state_d.ext_addr = pwdata[`CTRL_EXT_ADDR];
            state_d.split_bank_output_enable = pwdata[`CTRL_SPLIT_BANK];
            state_d.safety = pwdata[`CTRL_SAFETY];
            state_d.sync_io = pwdata[`CTRL_SYNC_IO];
            state_d.slave_b = pwdata[`CTRL_SLAVE_B];
            state_d.joint_inv = pwdata[`CTRL_JOINT_INV];
        end
        if (psel && penable && pwrite && paddr == `ADDR_INVERT) begin
            state_d.per_bit_input_invert_ctrl = pwdata[`INV_BIT_HI:`INV_BIT_LO];
            state_d.input_filter_ctrl = pwdata[`FILT_HI:`FILT_LO];
        end
        // read data captured in the setup cycle
        if (psel && !penable) begin
            unique case (paddr)
                `ADDR_CTRL: state_d.prdata = {26'h0000000, state_q.joint_inv, state_q.slave_b, state_q.sync_io,
                    state_q.safety, state_q.split_bank_output_enable, state_q.ext_addr};
                `ADDR_INVERT: state_d.prdata = {24'h000000, state_q.input_filter_ctrl,
                    state_q.per_bit_input_invert_ctrl};
                `ADDR_STATUS: state_d.prdata = {20'h00000, state_q.resp_data, state_q.dx_disable, state_q.prev_i2,
                    state_q.low_bank_hold_bit1, state_q.low_bank_hold_bit0, state_q.output_pin};
                default: state_d.prdata = `WORD_ZERO;
            endcase
        end
        // exchange disable: cleared by a parameter call unless locked
        if (lock) begin
            state_d.dx_disable = 1'b1;
        end else if (param_call) begin
            state_d.dx_disable = 1'b0;
        end
        if (accept) begin
            // inputs answered on every call
            state_d.resp_data = tx_data;
            state_d.resp_valid = 1'b1;
            if (four_mode) begin
                if (dexg_info[`INFO_I2]) begin
                    state_d.low_bank_hold_bit0 = dexg_info[`INFO_I0];
                    state_d.low_bank_hold_bit1 = dexg_info[`INFO_I1];
                    state_d.prev_i2 = 1'b1;
                end else begin
                    if (state_q.prev_i2) begin
                        state_d.output_pin = {dexg_info[`INFO_I1], dexg_info[`INFO_I0],
                            state_q.low_bank_hold_bit1, state_q.low_bank_hold_bit0};
                        state_d.data_strobe = 1'b1;
                    end
                    state_d.prev_i2 = 1'b0;
                end
            end else if (state_q.ext_addr) begin
                state_d.output_pin = {state_q.output_pin[3], dexg_info[2:0]};
                state_d.data_strobe = 1'b1;
            end else begin
                state_d.output_pin = dexg_info;
                state_d.data_strobe = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= '0;
            state_q.prev_i2 <= 1'b0;
            state_q.low_bank_hold_bit0 <= 1'b0;
            state_q.low_bank_hold_bit1 <= 1'b0;
            state_q.dx_disable <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign prdata = state_q.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign output_pin = state_q.output_pin;
    assign data_strobe = state_q.data_strobe;
    assign resp_data = state_q.resp_data;
    assign resp_valid = state_q.resp_valid;
    assign dx_disable = state_q.dx_disable;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_strobe_cause: assert property (
        data_strobe && $past(four_mode) |-> $past(accept) && !$past(dexg_info[2]) && $past(state_q.prev_i2))
        else $error("strobe without falling I2");
    a_hold_pins: assert property (
        accept && four_mode && dexg_info[2] |=> $stable(output_pin) && !data_strobe
        && state_q.low_bank_hold_bit0 == $past(dexg_info[0]) && state_q.low_bank_hold_bit1 == $past(dexg_info[1]))
        else $error("I2 high call misrouted");
    a_bank_output: assert property (
        accept && four_mode && !dexg_info[2] && state_q.prev_i2 |=> data_strobe
        && output_pin == {$past(dexg_info[1]), $past(dexg_info[0]),
        $past(state_q.low_bank_hold_bit1), $past(state_q.low_bank_hold_bit0)})
        else $error("bank output wrong");
    a_resp_every: assert property (
        accept |=> resp_valid && resp_data == $past(tx_data))
        else $error("response missing");
    a_ab_select: assert property (
        dexg_valid && state_q.ext_addr && dexg_info[3] != state_q.slave_b |=> !resp_valid)
        else $error("other slave answered");
    a_reset_prev: assert property (
        !$past(presetn) |-> !state_q.prev_i2 && !state_q.low_bank_hold_bit0)
        else $error("detector not cleared");
    a_safe_code: assert property (
        state_q.safety |-> tx_data[0] == ((input_pin[0] ^ state_q.joint_inv ^ state_q.per_bit_input_invert_ctrl[0])
        ^ (&(input_pin[3:1] ^ {3{state_q.joint_inv}} ^ state_q.per_bit_input_invert_ctrl[3:1]))))
        else $error("safety D0 wrong");
    a_swap_route: assert property (
        state_q.safety && $stable(input_pin) && $stable(state_q.per_bit_input_invert_ctrl)
        |-> tx_data[3] == (input_pin[2] ^ state_q.per_bit_input_invert_ctrl[2] ^ state_q.joint_inv))
        else $error("D3 not routed from pin two");
    a_std_forced: assert property (
        state_q.safety |-> std_path == 4'hF)
        else $error("standard path not forced");
    a_lock_dx: assert property (
        lock |=> dx_disable)
        else $error("exchange disable cleared");
endmodule : asi_bank_datapath

// ==== asi_master_model.sv ====
// far side model: master calls and input code generator
`timescale 1ns/1ps
module asi_master_model (
    input wire logic pclk,
    input wire logic safe_coding,
    output logic dexg_valid,
    output logic [3:0] dexg_info,
    output logic param_call,
    output logic [3:0] input_pin
);
    logic [3:0] code_q = 4'h0;
    logic [3:0] sent;
    initial begin
        dexg_valid = 1'b0;
        dexg_info = 4'h0;
        param_call = 1'b0;
    end
    assign sent = (safe_coding && code_q == 4'hE) ? 4'hF : code_q;
    assign input_pin = safe_coding ? {sent[2], sent[3], sent[1:0]} : sent;
    task call(input logic [3:0] info, input logic [3:0] code);
        @(posedge pclk);
        dexg_valid <= 1'b1;
        dexg_info <= info;
        code_q <= code;
        @(posedge pclk);
        dexg_valid <= 1'b0;
        dexg_info <= ~info;
    endtask : call
    task param();
        @(posedge pclk);
        param_call <= 1'b1;
        @(posedge pclk);
        param_call <= 1'b0;
    endtask : param
endmodule : asi_master_model

// ==== tb_asi_slave_bank_safety_datapath.sv ====
// testbench for the split bank and safety data path
`timescale 1ns/1ps
`include "asi_bank_defs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_asi_slave_bank_safety_datapath import asi_bank_pkg::*;;
    typedef struct {
        logic [5:0] ctrl;
        logic [7:0] inv;
        logic [3:0] info, din, resp;
        logic vld, stb;
        logic [3:0] out;
    } row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, safe_coding = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, dexg_valid, param_call, data_strobe, resp_valid, dx_disable, err;
    logic [3:0] dexg_info, input_pin, output_pin, resp_data;
    int n_fail = 0, n_checks = 0, cyc = 0, i;
    // ctrl, invert, info, code, resp, valid, strobe, outputs
    row_t rows[15] = '{
        '{6'h00, 8'h00, 4'hA, 4'h5, 4'h5, 1'b1, 1'b1, 4'hA},
        '{6'h00, 8'h03, 4'h3, 4'h5, 4'h6, 1'b1, 1'b1, 4'h3},
        '{6'h20, 8'h00, 4'h0, 4'h5, 4'hA, 1'b1, 1'b1, 4'h0},
        '{6'h01, 8'h00, 4'h8, 4'h9, 4'h0, 1'b0, 1'b0, 4'h0},
        '{6'h01, 8'h00, 4'h7, 4'h9, 4'h9, 1'b1, 1'b1, 4'h7},
        '{6'h03, 8'h00, 4'h6, 4'h3, 4'h3, 1'b1, 1'b0, 4'h7},
        '{6'h03, 8'h00, 4'h1, 4'h3, 4'h3, 1'b1, 1'b1, 4'h6},
        '{6'h03, 8'h00, 4'h2, 4'h4, 4'h4, 1'b1, 1'b0, 4'h6},
        '{6'h13, 8'h00, 4'hD, 4'h4, 4'h4, 1'b1, 1'b0, 4'h6},
        '{6'h13, 8'h00, 4'hB, 4'h4, 4'h4, 1'b1, 1'b1, 4'hD},
        '{6'h13, 8'h00, 4'h4, 4'h4, 4'h0, 1'b0, 1'b0, 4'hD},
        '{6'h04, 8'h00, 4'h5, 4'hE, 4'hE, 1'b1, 1'b1, 4'h5},
        '{6'h04, 8'h00, 4'h5, 4'hB, 4'hB, 1'b1, 1'b1, 4'h5},
        '{6'h04, 8'h08, 4'h5, 4'h0, 4'h4, 1'b1, 1'b1, 4'h5},
        '{6'h24, 8'h00, 4'h5, 4'h1, 4'hF, 1'b1, 1'b1, 4'h5}
    };
    asi_bank_datapath dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .dexg_valid, .dexg_info, .param_call, .input_pin, .output_pin, .data_strobe, .resp_data,
        .resp_valid, .dx_disable);
    asi_master_model m (.pclk, .safe_coding, .dexg_valid, .dexg_info, .param_call, .input_pin);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task do_reset();
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        #1;
        `CHK("reset outputs", {4'h0, 3'b001, 32'h0000_0000}, {output_pin, data_strobe, resp_valid, dx_disable, prdata})
        @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task lock_case(input logic [11:0] a, input logic [31:0] d, input logic e);
        apb(1'b1, a, d);
        m.param();
        #1;
        `CHK("exchange disable", e, dx_disable)
    endtask : lock_case
    task report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        do_reset();
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        `CHK("status after reset", 32'h0000_0080, rd)
        m.param();
        for (i = 0; i < 15; i++) begin
            safe_coding <= rows[i].ctrl[2];
            apb(1'b1, `ADDR_CTRL, {26'h0, rows[i].ctrl});
            apb(1'b1, `ADDR_INVERT, {24'h0, rows[i].inv});
            m.call(rows[i].info, rows[i].din);
            #1;
            if (rows[i].vld) `CHK("resp", rows[i].resp, resp_data)
            `CHK("valid", rows[i].vld, resp_valid)
            `CHK("strobe", rows[i].stb, data_strobe)
            `CHK("outputs", rows[i].out, output_pin)
        end
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        `CHK("status", 32'h0000_0F15, rd)
        apb(1'b0, 12'h00C, 32'h0000_0000);
        `CHK("unmapped", 33'h1_0000_0000, {err, rd})
        lock_case(`ADDR_INVERT, 32'h0000_0010, 1'b1);
        lock_case(`ADDR_INVERT, 32'h0000_0000, 1'b0);
        lock_case(`ADDR_CTRL, 32'h0000_000C, 1'b1);
        m.call(4'h0, 4'h0);
        #1;
        `CHK("locked call", 1'b0, resp_valid)
        do_reset();
        safe_coding <= 1'b0;
        apb(1'b1, `ADDR_CTRL, 32'h0000_0003);
        m.param();
        m.call(4'h0, 4'h0);
        #1;
        `CHK("first low call", 1'b0, data_strobe)
        m.call(4'h5, 4'h0);
        m.call(4'h0, 4'h0);
        #1;
        `CHK("paired outputs", 5'h11, {data_strobe, output_pin})
        report_and_stop();
    end
endmodule : tb_asi_slave_bank_safety_datapath
